// *** sensor_spi_cfg.svh ***
// Offsets, field positions and timing counts of the sensor serial port.
// Assumes the system clock runs at 40 MHz.
`ifndef SENSOR_SPI_CFG_SVH
`define SENSOR_SPI_CFG_SVH

`define SYS_CLK_MHZ        40
`define WORD_BITS          16
`define ADDR_BITS          7
`define WRITE_BIT          15
`define ADDR_MSB           14
`define ADDR_LSB           8
`define SYNC_TO_READY_US   600
`define SYNC_TO_READY_CYC  (`SYNC_TO_READY_US * `SYS_CLK_MHZ)
`define READY_PULSE_CYC    4
`define FIFO_DEPTH         4
`define MEM_WORDS          64

`endif

// *** sensor_spi_pkg.sv ***
// Types shared by the sensor serial port.
// Assumes sensor_spi_cfg.svh is compiled alongside.
package sensor_spi_pkg;

  // One received word headed for the register store
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } cmd_s;

  // Sync pacing state, one-bit steps except the return from SYNC_RDY to SYNC_IDLE
  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b00,
    SYNC_WAIT = 2'b01,
    SYNC_RDY  = 2'b11
  } sync_e;

endpackage

// *** sensor_spi_fifo.sv ***
// Small FIFO carrying received words from the link to the system side.
// Assumes one clock; both sides use valid and ready.
`timescale 1ns/1ps
module sensor_spi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH)); // Full once DEPTH held
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // Storage and pointers
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** sensor_spi_slave.sv ***
// Serial slave port of the sensor with its sync-clock pacing.
// Assumes sclk comes from the master, cs_n marks one 16-bit word.
// What this block does
// - Data-ready pulses about 600 us after each sync rising edge that arrives while the pacing is idle.
// - Data-out shifts on serial clock falling edges and is retimed on the system clock.
// - Data-in is sampled on rising edges while selected.
// - Fourth io pin is general io or the sync clock input.
// - Clock mode 3, most significant bit first, 16-bit words.
// - Read word returns addressed register during the next word.
// - Word with top bit set writes low byte at frame end.
`timescale 1ns/1ps
`include "sensor_spi_cfg.svh"
module sensor_spi_slave (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic din,
  output logic      dout,
  input  wire logic sync_mode,
  input  wire logic io_four_or_sync_clock_in,
  output logic      io_four_or_sync_clock_out,
  output logic      io_four_or_sync_clock_oe,
  input  wire logic io_four_out_value,
  input  wire logic io_four_drive,
  output logic      io_four_in_value,
  output logic      data_ready
);
  // Link domain: shift register and reply word
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [3:0]  bit_cnt;
  logic [15:0] rx_word;
  logic        rx_toggle;
  logic [15:0] reply;
  logic        tx_loaded;

  // Capture on rising edges while selected; word done at bit 16
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt  <= bit_cnt + 4'h1;
      rx_shift <= {rx_shift[14:0], din};
      if (bit_cnt == 4'hf) begin
        rx_word <= {rx_shift[14:0], din};
      end
    end
  end

  // Word-done toggle; system reset clears it so the crossing starts known
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      rx_toggle <= 1'b0;
    end else if (!cs_n && bit_cnt == 4'hf) begin
      rx_toggle <= ~rx_toggle;
    end
  end

  // Shift out on falling edges, MSB first; the first fall loads the reply.
  // The reply settles a few system clocks after a word, well inside the
  // stall gap, so it is steady when the next word starts.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_shift  <= '0;
      tx_loaded <= 1'b0;
    end else if (!tx_loaded) begin
      tx_shift  <= reply;
      tx_loaded <= 1'b1;
    end else begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  // System domain crossing of the word-done toggle
  logic [2:0]  tog_sync;
  logic        word_level;
  logic        word_evt;
  sensor_spi_pkg::cmd_s cmd;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tog_sync <= '0;
    end else begin
      tog_sync <= {tog_sync[1:0], rx_toggle};
    end
  end
  // Toggle level seen so far; a change counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      word_level <= 1'b0;
    end else if (tog_sync[2] == tog_sync[1]) begin
      word_level <= tog_sync[2];
    end
  end
  assign word_evt = (tog_sync[2] == tog_sync[1]) &&
                    (tog_sync[2] != word_level);
  assign cmd      = sensor_spi_pkg::cmd_s'(rx_word);

  // Buffer received words
  logic [15:0] f_data;
  logic        f_valid;
  logic        f_ready;
  logic        f_in_ready;
  sensor_spi_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_data   (cmd),
    .in_valid  (word_evt),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );
  assign f_ready = 1'b1;

  // A finished word always finds room in the buffer
  a_fifo_room: assert property (
    @(posedge clk_sys) disable iff (reset)
    word_evt |-> f_in_ready)
    else $error("received word dropped by full buffer");

  // Byte register store; writes at end of frame, reads queue reply
  logic [7:0] mem [`MEM_WORDS*2];
  sensor_spi_pkg::cmd_s head;
  assign head = sensor_spi_pkg::cmd_s'(f_data);
  always_ff @(posedge clk_sys) begin
    if (f_valid && head.write) begin
      mem[head.addr] <= head.data;
    end
  end

  // A write word lands at its byte address one cycle later
  a_write_lands: assert property (
    @(posedge clk_sys) disable iff (reset)
    f_valid && head.write |=> mem[$past(head.addr)] == $past(head.data))
    else $error("received write not stored");

  logic [15:0] reply_sys;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reply_sys <= '0;
    end else if (f_valid && !head.write) begin
      reply_sys <= {mem[{head.addr[6:1], 1'b1}],
                    mem[{head.addr[6:1], 1'b0}]};
    end
  end
  // Stable long before next select falls (stall gap)
  assign reply = reply_sys;

  // Data-out retimed on the system clock, low while deselected
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dout <= 1'b0;
    end else begin
      dout <= cs_n ? 1'b0 : tx_shift[15];
    end
  end

  // Fourth io pin: general io or sync input
  logic [2:0] pin_sync;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_sync <= '0;
    end else begin
      pin_sync <= {pin_sync[1:0], io_four_or_sync_clock_in};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      io_four_or_sync_clock_oe  <= 1'b0;
      io_four_or_sync_clock_out <= 1'b0;
      io_four_in_value          <= 1'b0;
    end else begin
      io_four_or_sync_clock_oe  <= io_four_drive && !sync_mode;
      io_four_or_sync_clock_out <= io_four_out_value;
      if (pin_sync[2] == pin_sync[1]) begin
        io_four_in_value <= pin_sync[2];
      end
    end
  end

  // Sync rising edge starts a 600 us delay to data-ready
  logic sync_level;
  logic sync_rise;
  sensor_spi_pkg::sync_e state;
  logic [15:0] delay;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_level <= 1'b0;
    end else if (pin_sync[2] == pin_sync[1]) begin
      sync_level <= pin_sync[2];
    end
  end
  assign sync_rise = sync_mode && !sync_level &&
                     (pin_sync[2] == pin_sync[1]) && pin_sync[2];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state      <= sensor_spi_pkg::SYNC_IDLE;
      delay      <= '0;
      data_ready <= 1'b0;
    end else begin
      case (state)
        sensor_spi_pkg::SYNC_IDLE: begin
          data_ready <= 1'b0;
          if (sync_rise) begin
            delay <= 16'(`SYNC_TO_READY_CYC - 1);
            state <= sensor_spi_pkg::SYNC_WAIT;
          end
        end
        sensor_spi_pkg::SYNC_WAIT: begin
          if (delay == 16'h0000) begin
            data_ready <= 1'b1;
            delay      <= 16'(`READY_PULSE_CYC - 1);
            state      <= sensor_spi_pkg::SYNC_RDY;
          end else begin
            delay <= delay - 16'h0001;
          end
        end
        sensor_spi_pkg::SYNC_RDY: begin
          if (delay == 16'h0000) begin
            data_ready <= 1'b0;
            state      <= sensor_spi_pkg::SYNC_IDLE;
          end else begin
            delay <= delay - 16'h0001;
          end
        end
        default: state <= sensor_spi_pkg::SYNC_IDLE;
      endcase
    end
  end

  // Data-ready stays low as the sync delay starts and rises only out of the wait state
  a_sync_ready_delay: assert property (
    @(posedge clk_sys) disable iff (reset)
    sync_rise && state == sensor_spi_pkg::SYNC_IDLE |=>
    state == sensor_spi_pkg::SYNC_WAIT && !data_ready)
    else $error("data-ready not delayed after sync edge");
  a_ready_from_wait: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(data_ready) |-> $past(state) == sensor_spi_pkg::SYNC_WAIT)
    else $error("data-ready raised outside the sync delay");
  a_ready_pulse_len: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(data_ready) |-> data_ready [*4] ##1 !data_ready)
    else $error("data-ready pulse length wrong");
  a_pin_released: assert property (
    @(posedge clk_sys) disable iff (reset)
    sync_mode |=> !io_four_or_sync_clock_oe)
    else $error("io pin driven in sync mode");
  a_dout_idle: assert property (
    @(posedge clk_sys) disable iff (reset)
    cs_n |=> !dout)
    else $error("data-out active while deselected");
endmodule

// *** spi_master_model.sv ***
// Serial bus master model for the sensor port, clock mode 3.
// Assumes the bench calls xfer for each word, one call at a time.
`timescale 1ns/1ps
module spi_master_model #(
  parameter int HALF_NS = 250
) (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  // Idle bus: clock parked high, not selected
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // One word, msb first, full duplex, then the stall gap
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #7; // Keeps link edges off the system clock edges
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #(HALF_NS) sclk = 1'b0;
      din = tx[i];
      #(HALF_NS) sclk = 1'b1;
      rx[i] = dout;
    end
    #(HALF_NS) cs_n = 1'b1;
    din = ~din; // Released line shows no stale bit
    #9000;
  endtask
endmodule

// *** test_sensor_spi_slave.sv ***
// Self-checking bench for the sensor serial port and sync pacing.
// Assumes spi_master_model stands in for the master processor.
`timescale 1ns/1ps
module test_sensor_spi_slave;
  logic clk_sys, reset, sclk, cs_n, din, dout, sync_mode, pin_ext;
  logic pin, io_out, io_oe, io_val, io_drv, io_in, data_ready;
  int   err_count = 0;
  int   checked   = 0;
  // Resolved level of the fourth io pin
  assign pin = io_oe ? io_out : pin_ext;
  sensor_spi_slave u_dut (.clk_sys(clk_sys), .reset(reset), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .sync_mode(sync_mode),
    .io_four_or_sync_clock_in(pin), .io_four_or_sync_clock_out(io_out),
    .io_four_or_sync_clock_oe(io_oe), .io_four_out_value(io_val),
    .io_four_drive(io_drv), .io_four_in_value(io_in),
    .data_ready(data_ready));
  spi_master_model u_master (.sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout));
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Byte writes, then chained full-duplex reads incl. top address
  task automatic test_write_read();
    logic [15:0] rx;
    u_master.xfer(16'ha03c, rx);
    u_master.xfer(16'ha15a, rx);
    u_master.xfer(16'hfe81, rx);
    u_master.xfer(16'hffa5, rx);
    u_master.xfer(16'h2000, rx);
    u_master.xfer(16'h7e00, rx);
    check("read 20", rx, 16'h5a3c);
    u_master.xfer(16'h2100, rx);
    check("read 7e", rx, 16'ha581);
    u_master.xfer(16'h0000, rx);
    check("read 21", rx, 16'h5a3c);
    $display("write and read done");
  endtask
  // Fourth pin as general io, driven and then as input
  task automatic test_gpio();
    @(posedge clk_sys);
    io_drv <= 1'b1;
    io_val <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    check("io oe on", 16'(io_oe), 16'h1);
    check("io out", 16'(io_out), 16'h1);
    check("io in drv", 16'(io_in), 16'h1);
    @(posedge clk_sys);
    io_drv  <= 1'b0;
    pin_ext <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    check("io oe off", 16'(io_oe), 16'h0);
    check("io in ext", 16'(io_in), 16'h0);
    $display("general io done");
  endtask
  // Sync pulse paces data ready; pin stays input despite drive
  task automatic test_sync();
    int n;
    @(posedge clk_sys);
    sync_mode <= 1'b1;
    io_drv    <= 1'b1;
    pin_ext   <= 1'b1;
    repeat (200) @(posedge clk_sys);
    pin_ext <= 1'b0;
    n = 200;
    while (data_ready !== 1'b1 && n < 25000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("ready delay", 16'(n >= 23995 && n <= 24010), 16'h1);
    n = 0;
    while (data_ready === 1'b1 && n < 10) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("ready width", 16'(n), 16'h4);
    check("sync oe", 16'(io_oe), 16'h0);
    $display("sync pacing done");
  endtask
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Watchdog
  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    reset     = 1'b1;
    sync_mode = 1'b0;
    pin_ext   = 1'b0;
    io_val    = 1'b0;
    io_drv    = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    test_write_read();
    test_gpio();
    test_sync();
    wrap_up();
  end
endmodule
